// file: logic/fdl_link_pkg.sv
// Constants for the facility data link buffer block
package fdl_link_pkg;
  localparam int unsigned ADDR_W = 9;
  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_RX_BYTE = 7'h28;
  localparam logic [6:0] IDX_MATCH_A = 7'h29;
  localparam logic [6:0] IDX_MATCH_B = 7'h2a;
  localparam logic [6:0] IDX_TX_BYTE = 7'h7e;
  localparam logic [6:0] IDX_CTRL = 7'h40;
  localparam logic [6:0] IDX_STATUS = 7'h41;
  localparam logic [6:0] IDX_MASK = 7'h42;
  // Control fields
  localparam int unsigned CTRL_DESTUFF_BIT = 0;
  localparam int unsigned CTRL_ESF_BIT = 1;
  localparam int unsigned CTRL_STUFF_BIT = 4;
  localparam logic [7:0] CTRL_USED = 8'h13;
  // Status and mask fields
  localparam int unsigned FLAG_MATCH_BIT = 2;
  localparam int unsigned FLAG_EMPTY_BIT = 3;
  localparam int unsigned FLAG_FULL_BIT = 4;
  localparam logic [7:0] FLAG_USED = 8'h1c;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Bit counting
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] RUN_STUFF = 3'h5;
  localparam logic [2:0] RUN_SAT = 3'h6;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: logic/fdl_link_buffer.sv
// Facility data link / Fs bit buffer with AXI4-Lite register access
// Functional notes
// - ESF uses FDL bits, D4 uses Fs bits
// - Eight received bits fill byte, set full flag
// - Unmasked full flag drives interrupt low
// - Byte equal to either match sets flag
// - First received bit lands in LSB
// - Delete zero after exactly five ones
// - Keep zero after six or more ones
// - Written byte sent serially, LSB first
// - After eight bits sent, set empty flag
// - Unmasked empty flag drives interrupt low
// - Without new write, previous byte repeats
// - Insert zero after five sent ones
// - Mask zero blocks source, one passes it
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module fdl_link_buffer
  import fdl_link_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [ADDR_W-1:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  input wire logic i_rx_fdl_strobe,
  input wire logic i_rx_fs_strobe,
  input wire logic i_rx_link_bit,
  input wire logic i_tx_fdl_strobe,
  input wire logic i_tx_fs_strobe,
  output logic o_tx_link_bit,
  output logic o_int_b
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] rx_byte;
    logic [7:0] match_a;
    logic [7:0] match_b;
    logic [7:0] tx_byte;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [2:0] rx_cnt;
    logic [2:0] tx_cnt;
    logic [2:0] rx_ones;
    logic [2:0] tx_ones;
    logic [7:0] ctrl;
    logic [7:0] status;
    logic [7:0] mask;
    logic tx_bit;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RESET = '{
    rx_byte: BYTE_RESET, match_a: BYTE_RESET, match_b: BYTE_RESET,
    tx_byte: BYTE_RESET, rx_shift: BYTE_RESET, tx_shift: BYTE_RESET,
    rx_cnt: 3'h0, tx_cnt: 3'h0, rx_ones: 3'h0, tx_ones: 3'h0,
    ctrl: CTRL_RESET, status: FLAG_RESET, mask: MASK_RESET,
    tx_bit: 1'b0, aw_full: 1'b0, aw_addr: '0, w_full: 1'b0,
    w_data: 8'h00, w_lane0: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY,
    rvalid: 1'b0, rdata: 8'h00, rresp: RESP_OKAY
  };

  state_t q_reg;
  state_t q_next;

  function automatic logic at_index(input logic [ADDR_W-1:0] addr,
                                    input logic [6:0] idx);
    at_index = (addr == {idx, 2'h0});
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = at_index(addr, IDX_RX_BYTE) || at_index(addr, IDX_MATCH_A) ||
             at_index(addr, IDX_MATCH_B) || at_index(addr, IDX_TX_BYTE) ||
             at_index(addr, IDX_CTRL) || at_index(addr, IDX_STATUS) ||
             at_index(addr, IDX_MASK);
  endfunction

  function automatic logic [2:0] run_next(input logic [2:0] ones,
                                          input logic bit_in);
    if (!bit_in)
      run_next = 3'h0;
    else if (ones >= RUN_SAT)
      run_next = RUN_SAT;
    else
      run_next = ones + 3'h1;
  endfunction

  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic rx_take;
  logic rx_del;
  logic rx_keep;
  logic [7:0] rx_word;
  logic tx_take;
  logic stuff_now;
  logic [7:0] tx_cur;
  logic tx_bit_now;

  assign o_axi_awready = !q_reg.aw_full && !q_reg.bvalid;
  assign o_axi_wready = !q_reg.w_full && !q_reg.bvalid;
  assign o_axi_arready = !q_reg.rvalid;
  assign o_axi_bvalid = q_reg.bvalid;
  assign o_axi_bresp = q_reg.bresp;
  assign o_axi_rvalid = q_reg.rvalid;
  assign o_axi_rdata = {24'h000000, q_reg.rdata};
  assign o_axi_rresp = q_reg.rresp;
  assign o_tx_link_bit = q_reg.tx_bit;
  assign o_int_b = ~|(q_reg.status & q_reg.mask);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    q_next = q_reg;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    // Link strobe chosen by framing mode
    rx_take = q_reg.ctrl[CTRL_ESF_BIT] ? i_rx_fdl_strobe
                                        : i_rx_fs_strobe;
    tx_take = q_reg.ctrl[CTRL_ESF_BIT] ? i_tx_fdl_strobe
                                        : i_tx_fs_strobe;
    // Receive: zero after exactly five ones is dropped
    rx_del = rx_take && q_reg.ctrl[CTRL_DESTUFF_BIT] && !i_rx_link_bit &&
             (q_reg.rx_ones == RUN_STUFF);
    rx_keep = rx_take && !rx_del;
    rx_word = {i_rx_link_bit, q_reg.rx_shift[7:1]};
    if (rx_take)
      q_next.rx_ones = run_next(q_reg.rx_ones, i_rx_link_bit);
    if (rx_keep)
    begin
      q_next.rx_shift = rx_word;
      q_next.rx_cnt = q_reg.rx_cnt + 3'h1;
      if (q_reg.rx_cnt == LAST_BIT)
      begin
        q_next.rx_byte = rx_word;
        flag_set[FLAG_FULL_BIT] = 1'b1;
        if (rx_word == q_reg.match_a || rx_word == q_reg.match_b)
          flag_set[FLAG_MATCH_BIT] = 1'b1;
      end
    end
    // Transmit: byte is sampled when its first bit goes out
    stuff_now = q_reg.ctrl[CTRL_STUFF_BIT] &&
                (q_reg.tx_ones == RUN_STUFF);
    tx_cur = (q_reg.tx_cnt == 3'h0) ? q_reg.tx_byte : q_reg.tx_shift;
    tx_bit_now = stuff_now ? 1'b0 : tx_cur[q_reg.tx_cnt];
    q_next.tx_bit = tx_bit_now;
    if (tx_take)
    begin
      if (stuff_now)
        q_next.tx_ones = 3'h0;
      else
      begin
        q_next.tx_ones = run_next(q_reg.tx_ones, tx_bit_now);
        if (q_reg.tx_cnt == 3'h0)
          q_next.tx_shift = q_reg.tx_byte;
        q_next.tx_cnt = q_reg.tx_cnt + 3'h1;
        if (q_reg.tx_cnt == LAST_BIT)
          flag_set[FLAG_EMPTY_BIT] = 1'b1;
      end
    end
    // Write channel: address and data in either order
    aw_hs = i_axi_awvalid && o_axi_awready;
    w_hs = i_axi_wvalid && o_axi_wready;
    wr_addr = q_reg.aw_full ? q_reg.aw_addr : i_axi_awaddr;
    wr_data = q_reg.w_full ? q_reg.w_data : i_axi_wdata[7:0];
    wr_lane0 = q_reg.w_full ? q_reg.w_lane0 : i_axi_wstrb[0];
    do_write = (q_reg.aw_full || aw_hs) && (q_reg.w_full || w_hs);
    if (aw_hs)
    begin
      q_next.aw_full = 1'b1;
      q_next.aw_addr = i_axi_awaddr;
    end
    if (w_hs)
    begin
      q_next.w_full = 1'b1;
      q_next.w_data = i_axi_wdata[7:0];
      q_next.w_lane0 = i_axi_wstrb[0];
    end
    if (q_reg.bvalid && i_axi_bready)
      q_next.bvalid = 1'b0;
    if (do_write)
    begin
      q_next.aw_full = 1'b0;
      q_next.w_full = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_lane0)
      begin
        if (at_index(wr_addr, IDX_MATCH_A))
          q_next.match_a = wr_data;
        if (at_index(wr_addr, IDX_MATCH_B))
          q_next.match_b = wr_data;
        if (at_index(wr_addr, IDX_TX_BYTE))
          q_next.tx_byte = wr_data;
        if (at_index(wr_addr, IDX_CTRL))
          q_next.ctrl = wr_data & CTRL_USED;
        if (at_index(wr_addr, IDX_MASK))
          q_next.mask = wr_data & FLAG_USED;
        if (at_index(wr_addr, IDX_STATUS))
          flag_clr = wr_data & FLAG_USED;
      end
    end
    // A new event wins over a clear in the same cycle
    q_next.status = (q_reg.status & ~flag_clr) | flag_set;
    // Read channel
    if (q_reg.rvalid && i_axi_rready)
      q_next.rvalid = 1'b0;
    if (i_axi_arvalid && o_axi_arready)
    begin
      q_next.rvalid = 1'b1;
      q_next.rresp = mapped(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      q_next.rdata = 8'h00;
      if (at_index(i_axi_araddr, IDX_RX_BYTE))
        q_next.rdata = q_reg.rx_byte;
      if (at_index(i_axi_araddr, IDX_MATCH_A))
        q_next.rdata = q_reg.match_a;
      if (at_index(i_axi_araddr, IDX_MATCH_B))
        q_next.rdata = q_reg.match_b;
      if (at_index(i_axi_araddr, IDX_TX_BYTE))
        q_next.rdata = q_reg.tx_byte;
      if (at_index(i_axi_araddr, IDX_CTRL))
        q_next.rdata = q_reg.ctrl;
      if (at_index(i_axi_araddr, IDX_STATUS))
        q_next.rdata = q_reg.status;
      if (at_index(i_axi_araddr, IDX_MASK))
        q_next.rdata = q_reg.mask;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      q_reg <= STATE_RESET;
    else
      q_reg <= q_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  AST_MODE_SELECT: assert property (
    (q_reg.ctrl[CTRL_ESF_BIT] && i_rx_fs_strobe && !i_rx_fdl_strobe)
    |=> $stable(q_reg.rx_cnt) && $stable(q_reg.rx_shift))
    else $error("Fs strobe moved receive byte in ESF mode");

  AST_RX_FULL: assert property (
    (rx_keep && q_reg.rx_cnt == LAST_BIT) |=> q_reg.status[FLAG_FULL_BIT])
    else $error("Full flag not set after eighth bit");

  AST_RX_FULL_INT: assert property (
    (rx_keep && q_reg.rx_cnt == LAST_BIT && q_reg.mask[FLAG_FULL_BIT] &&
     !(do_write && at_index(wr_addr, IDX_MASK))) |=> !o_int_b)
    else $error("Interrupt not low on unmasked full");

  AST_MATCH: assert property (
    (rx_keep && q_reg.rx_cnt == LAST_BIT && rx_word == q_reg.match_a)
    |=> q_reg.status[FLAG_MATCH_BIT] && q_reg.rx_byte == q_reg.match_a)
    else $error("Match flag missing");

  AST_LSB_FIRST: assert property (
    (rx_keep && q_reg.rx_cnt == LAST_BIT)
    |=> q_reg.rx_byte[7] == $past(i_rx_link_bit) &&
        q_reg.rx_byte[0] == $past(q_reg.rx_shift[1]))
    else $error("Receive bit order wrong");

  AST_DESTUFF: assert property (
    (rx_take && q_reg.ctrl[CTRL_DESTUFF_BIT] && !i_rx_link_bit &&
     q_reg.rx_ones == RUN_STUFF) |=> $stable(q_reg.rx_cnt))
    else $error("Stuffed zero not deleted");

  AST_NO_DESTUFF_SIX: assert property (
    (rx_take && !i_rx_link_bit && q_reg.rx_ones == RUN_SAT)
    |=> q_reg.rx_cnt != $past(q_reg.rx_cnt))
    else $error("Zero after six ones deleted");

  AST_TX_LOAD: assert property (
    (tx_take && !stuff_now && q_reg.tx_cnt == 3'h0)
    |=> q_reg.tx_shift == $past(q_reg.tx_byte) && q_reg.tx_cnt == 3'h1)
    else $error("Transmit byte not taken at byte start");

  AST_TX_EMPTY: assert property (
    (tx_take && !stuff_now && q_reg.tx_cnt == LAST_BIT)
    |=> q_reg.status[FLAG_EMPTY_BIT] && q_reg.tx_cnt == 3'h0)
    else $error("Empty flag not set after eighth bit");

  AST_EMPTY_INT: assert property (
    (tx_take && !stuff_now && q_reg.tx_cnt == LAST_BIT &&
     q_reg.mask[FLAG_EMPTY_BIT] &&
     !(do_write && at_index(wr_addr, IDX_MASK))) |=> !o_int_b)
    else $error("Interrupt not low on unmasked empty");

  AST_STUFF: assert property (
    (tx_take && stuff_now)
    |-> !o_tx_link_bit ##1 ($stable(q_reg.tx_cnt) && q_reg.tx_ones == 3'h0))
    else $error("Zero not inserted after five ones");

  AST_MASK_BLOCK: assert property (
    ((q_reg.status & q_reg.mask) == 8'h00) |-> o_int_b)
    else $error("Masked source drove interrupt");

  AST_SET_WINS: assert property (
    (rx_keep && q_reg.rx_cnt == LAST_BIT && do_write && wr_lane0 &&
     at_index(wr_addr, IDX_STATUS)) |=> q_reg.status[FLAG_FULL_BIT])
    else $error("Clear beat a new full event");

  COV_FULL: cover property (rx_keep && q_reg.rx_cnt == LAST_BIT);
  COV_MATCH: cover property (flag_set[FLAG_MATCH_BIT]);
  COV_DESTUFF: cover property (rx_del);
  COV_STUFF: cover property (tx_take && stuff_now);

endmodule // fdl_link_buffer
`default_nettype wire

// file: sim/framer_model.sv
// Framer bit stream model facing the link buffer
`timescale 1ns/10ps
`default_nettype none
module framer_model
(
  input wire logic i_clock,
  input wire logic i_esf,
  output logic o_rx_fdl_strobe,
  output logic o_rx_fs_strobe,
  output logic o_rx_link_bit,
  output logic o_tx_fdl_strobe,
  output logic o_tx_fs_strobe,
  input wire logic i_tx_link_bit
);
  initial
  begin
    o_rx_fdl_strobe = 1'b0;
    o_rx_fs_strobe = 1'b0;
    o_rx_link_bit = 1'b0;
    o_tx_fdl_strobe = 1'b0;
    o_tx_fs_strobe = 1'b0;
  end
  // One slot every three cycles; data line inverted outside its slot
  task automatic put_bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      o_rx_link_bit <= v[i];
      o_rx_fdl_strobe <= i_esf;
      o_rx_fs_strobe <= !i_esf;
      @(posedge i_clock);
      o_rx_fdl_strobe <= 1'b0;
      o_rx_fs_strobe <= 1'b0;
      o_rx_link_bit <= !v[i];
      repeat (2) @(posedge i_clock);
    end
  endtask
  task automatic get_bits(input int n, output logic [15:0] v);
    v = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      o_tx_fdl_strobe <= i_esf;
      o_tx_fs_strobe <= !i_esf;
      // Sample mid-cycle; this is the bit used at the coming edge
      @(negedge i_clock);
      v[i] = i_tx_link_bit;
      @(posedge i_clock);
      o_tx_fdl_strobe <= 1'b0;
      o_tx_fs_strobe <= 1'b0;
      repeat (2) @(posedge i_clock);
    end
  endtask
endmodule // framer_model
`default_nettype wire

// file: sim/tb_fdl_link_buffer.sv
// Self-checking bench for the link buffer
`timescale 1ns/10ps
`default_nettype none
module tb_fdl_link_buffer
  import fdl_link_pkg::*;
;
  logic i_clock, rst_b, awv, wv, bready, arv, rready, esf;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, int_b, tx_bit;
  logic rfs, rss, rbit, tfs, tss;
  logic [3:0] strb;
  logic [15:0] v;
  logic [6:0] idx_tab [7] = '{IDX_RX_BYTE, IDX_MATCH_A, IDX_MATCH_B,
    IDX_TX_BYTE, IDX_CTRL, IDX_STATUS, IDX_MASK};
  int error_cnt = 0;
  int comparisons = 0;
  always #2.5 i_clock = ~i_clock;
  fdl_link_buffer dut (.i_clock(i_clock), .i_rst_b(rst_b),
    .i_axi_awvalid(awv), .o_axi_awready(awrdy), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wv), .o_axi_wready(wrdy), .i_axi_wdata(wdata),
    .i_axi_wstrb(strb), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .o_axi_bresp(bresp), .i_axi_arvalid(arv), .o_axi_arready(arrdy),
    .i_axi_araddr(araddr), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_rx_fdl_strobe(rfs),
    .i_rx_fs_strobe(rss), .i_rx_link_bit(rbit), .i_tx_fdl_strobe(tfs),
    .i_tx_fs_strobe(tss), .o_tx_link_bit(tx_bit), .o_int_b(int_b));
  framer_model fm (.i_clock(i_clock), .i_esf(esf), .o_rx_fdl_strobe(rfs),
    .o_rx_fs_strobe(rss), .o_rx_link_bit(rbit), .o_tx_fdl_strobe(tfs),
    .o_tx_fs_strobe(tss), .i_tx_link_bit(tx_bit));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] ad(input logic [6:0] i);
    return {i, 2'b00};
  endfunction
  task automatic wr(input logic [6:0] i, input logic [31:0] w);
    awv <= 1'b1;
    awaddr <= ad(i);
    wv <= 1'b1;
    wdata <= w;
    bready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic rd(input logic [6:0] i);
    arv <= 1'b1;
    araddr <= ad(i);
    rready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (arv && arrdy) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge i_clock);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    i_clock = 1'b0;
    rst_b = 1'b0;
    {awv, wv, bready, arv, rready, esf} = 6'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    strb = 4'hf;
    repeat (12) @(posedge i_clock);
    rst_b <= 1'b1;
    @(posedge i_clock);
    for (int i = 0; i < 7; i++)
    begin
      rd(idx_tab[i]);
      chk(d, 32'h0);
      chk(r, RESP_OKAY);
    end
    wr(IDX_MATCH_A, 32'h55);
    wr(IDX_MATCH_B, 32'hc3);
    strb <= 4'he;
    wr(IDX_MATCH_A, 32'h99);
    chk(r, RESP_OKAY);
    strb <= 4'hf;
    rd(IDX_MATCH_A);
    chk(d, 32'h55);
    wr(IDX_RX_BYTE, 32'hff);
    chk(r, RESP_OKAY);
    wr(7'h10, 32'h1);
    chk(r, RESP_SLVERR);
    rd(7'h10);
    chk(r, RESP_SLVERR);
    rd(IDX_MATCH_B);
    chk(d, 32'hc3);
    rd(IDX_RX_BYTE);
    chk(d, 32'h0);
    $display("test registers done");
    wr(IDX_CTRL, 32'h02);
    esf <= 1'b1;
    wr(IDX_MASK, 32'h10);
    fm.put_bits(16'h0055, 8);
    rd(IDX_RX_BYTE);
    chk(d, 32'h55);
    rd(IDX_STATUS);
    chk(d, 32'h14);
    chk(int_b, 32'h0);
    wr(IDX_STATUS, 32'h14);
    chk(int_b, 32'h1);
    wr(IDX_MASK, 32'h04);
    fm.put_bits(16'h00c3, 8);
    rd(IDX_STATUS);
    chk(d, 32'h14);
    chk(int_b, 32'h0);
    wr(IDX_STATUS, 32'h14);
    esf <= 1'b0;
    wr(IDX_MASK, 32'h14);
    fm.put_bits(16'h00aa, 8);
    rd(IDX_STATUS);
    chk(d, 32'h0);
    chk(int_b, 32'h1);
    wr(IDX_CTRL, 32'h00);
    esf <= 1'b0;
    wr(IDX_MASK, 32'h00);
    fm.put_bits(16'h003c, 8);
    rd(IDX_RX_BYTE);
    chk(d, 32'h3c);
    chk(int_b, 32'h1);
    $display("test receive done");
    wr(IDX_CTRL, 32'h01);
    fm.put_bits(16'h009f, 9);
    rd(IDX_RX_BYTE);
    chk(d, 32'h5f);
    fm.put_bits(16'h003f, 8);
    rd(IDX_RX_BYTE);
    chk(d, 32'h3f);
    $display("test destuff done");
    wr(IDX_STATUS, 32'h1c);
    wr(IDX_CTRL, 32'h02);
    esf <= 1'b1;
    wr(IDX_TX_BYTE, 32'h5a);
    fm.get_bits(8, v);
    chk(v, 32'h5a);
    rd(IDX_STATUS);
    chk(d, 32'h08);
    wr(IDX_MASK, 32'h08);
    chk(int_b, 32'h0);
    wr(IDX_STATUS, 32'h08);
    fm.get_bits(8, v);
    chk(v, 32'h5a);
    rd(IDX_STATUS);
    chk(d, 32'h08);
    wr(IDX_CTRL, 32'h12);
    wr(IDX_TX_BYTE, 32'hff);
    fm.get_bits(9, v);
    chk(v, 32'h1df);
    $display("test transmit done");
    tally_and_finish();
  end
endmodule // tb_fdl_link_buffer
`default_nettype wire
